// >>> design/cbsc_core.sv
// CardBus socket control: framing, arbitration, parity and socket sense
// Behaviour
// (R1) Binary card audio drives speaker output
// (R2) Lock pin both driven and observed
// (R3) Detect and voltage sense give insertion, type
// (R4) Claim target cycles with device select
// (R5) No device select by timeout: abort
// (R6) Frame held until final data phase
// (R7) Grant only after current transaction ends
// (R8) Low card interrupt means host interrupt
// (R9) Transfer when both ready lines asserted
// (R10) Parity error two clocks later, not special
// (R11) Card request is pending bus request
// (R12) Tolerate slow system error release
// (R13) Card system error forwarded upstream
// (R14) Target stop ends the transaction
// (R15) Status change is event and wake
// (R16) Even parity output one clock later
// (R17) Command in address, byte enables in data
// (R18) Device-select timeout is fixed parameter
module cbsc_core
   import cbsc_pkg::*;
#(
   parameter int unsigned ABORT_CLKS = cbsc_pkg::CBSC_ABORT_CLKS
) (
   // System clock domain
   input  wire logic               clock_i,
   input  wire logic               resetn_i,
   input  wire logic               clk_en_i,
   // Link clock
   input  wire logic               link_clk_i,
   // Host initiator request
   input  wire logic               req_valid_i,
   output logic                    req_ready_o,
   input  wire cbsc_pkg::cbsc_req_t req_i,
   output logic                    done_o,
   output logic                    abort_o,
   output logic [31:0]             rdata_o,
   // Host status
   input  wire logic               audio_en_i,
   output cbsc_pkg::cbsc_stat_t    stat_o,
   output logic                    serr_n_o,
   output logic                    stschg_o,
   output logic                    speaker_out_o,
   // Socket pins; control strobes active low, output enables active high
   input  wire logic               frame_n_i,
   output logic                    frame_n_o,
   output logic                    frame_oe_o,
   input  wire logic               irdy_n_i,
   output logic                    irdy_n_o,
   input  wire logic               trdy_n_i,
   output logic                    trdy_n_o,
   input  wire logic               devsel_n_i,
   output logic                    devsel_n_o,
   input  wire logic               stop_n_i,
   output logic                    ctl_oe_o,
   input  wire logic               lock_n_i,
   output logic                    lock_n_o,
   output logic                    lock_oe_o,
   input  wire logic               perr_n_i,
   output logic                    perr_n_o,
   output logic                    perr_oe_o,
   input  wire logic [31:0]        ad_i,
   output logic [31:0]             ad_o,
   output logic                    ad_oe_o,
   input  wire logic [3:0]         cbe_i,
   output logic [3:0]              cbe_o,
   input  wire logic               par_i,
   output logic                    par_o,
   output logic                    par_oe_o,
   input  wire logic               req_n_i,
   output logic                    gnt_n_o,
   input  wire logic               int_n_i,
   input  wire logic               serr_n_i,
   input  wire logic               stschg_i,
   input  wire logic               audio_i,
   input  wire cbsc_pkg::cbsc_sense_t sense_i
);
   import cbsc_pkg::*;

   // ----------------------------------------------------------------
   // Link side: initiator engine on the link clock
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {CBSC_IDLE, CBSC_ADDR, CBSC_DATA,
                             CBSC_TURN} cbsc_st_t;
   cbsc_st_t    st_q;
   logic [7:0]  wait_q;
   logic        lrst1_q, lrst_n_q;
   logic        req_t_s1_q, req_t_s2_q, req_t_seen_q;
   logic        done_t_q, abort_t_q;
   logic        par_en_q, par_q;
   logic        tgt_q, perr_p1_q, perr_p2_q, texp_q;
   logic [3:0]  tcmd_q;
   logic [3:0]  cmd_lat_q;
   logic        req_t_q;
   cbsc_req_t   req_lat_q;
   cbsc_req_t   req_lat_hold_q;

   // Reset release re-timed for the link domain
   always_ff @(posedge link_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lrst1_q  <= 1'b0;
         lrst_n_q <= 1'b0;
      end else begin
         lrst1_q  <= 1'b1;
         lrst_n_q <= lrst1_q;
      end
   end

   wire new_req_w   = req_t_s2_q != req_t_seen_q;
   wire xfer_w      = !irdy_n_o && !trdy_n_i;       // (R9)
   wire devsel_w    = !devsel_n_i;
   wire stop_w      = !stop_n_i;
   wire timeout_w   = wait_q >= 8'(ABORT_CLKS);     // (R18)
   // Even parity covers data plus byte enables
   wire par_calc_w  = ^{ad_o, cbe_o};                // (R16)
   wire rx_par_w    = ^{ad_i, cbe_i};
   // A card frame seen while we do not drive the bus and lock is released is ours to claim
   wire claim_w     = !frame_n_i && !ad_oe_o && lock_n_i;

   // Initiator state machine; frame drops for the single data phase
   always_ff @(posedge link_clk_i or negedge lrst_n_q) begin
      if (!lrst_n_q) begin
         st_q         <= CBSC_IDLE;
         wait_q       <= 8'h00;
         req_t_s1_q   <= 1'b0;
         req_t_s2_q   <= 1'b0;
         req_t_seen_q <= 1'b0;
         done_t_q     <= 1'b0;
         abort_t_q    <= 1'b0;
         rdata_o      <= 32'h0;
      end else begin
         req_t_s1_q <= req_t_q;
         req_t_s2_q <= req_t_s1_q;
         unique case (st_q)
            CBSC_IDLE: begin
               if (new_req_w && gnt_n_o) begin     // (R7)
                  req_t_seen_q <= req_t_s2_q;
                  st_q         <= CBSC_ADDR;
               end
            end
            CBSC_ADDR: begin
               wait_q <= 8'h00;
               st_q   <= CBSC_DATA;
            end
            CBSC_DATA: begin
               if (xfer_w || (devsel_w && stop_w)) begin  // (R14)
                  rdata_o  <= ad_i;
                  done_t_q <= ~done_t_q;
                  st_q     <= CBSC_TURN;
               end else if (!devsel_w && timeout_w) begin // (R5)
                  abort_t_q <= ~abort_t_q;
                  st_q      <= CBSC_TURN;
               end else begin
                  wait_q <= wait_q + 8'h01;
               end
            end
            CBSC_TURN: st_q <= CBSC_IDLE;
            default:   st_q <= CBSC_IDLE;
         endcase
      end
   end

   // Request words are stable while the toggle is in flight
   always_ff @(posedge link_clk_i or negedge lrst_n_q) begin
      if (!lrst_n_q) begin
         cmd_lat_q <= CBSC_CMD_IDLE;
      end else if (st_q == CBSC_IDLE && new_req_w) begin
         cmd_lat_q <= req_lat_hold_q.cmd;
      end
   end

   // Pin drive from the engine state and the target claim
   assign frame_oe_o = st_q == CBSC_ADDR || st_q == CBSC_DATA;
   assign frame_n_o  = st_q != CBSC_ADDR;                 // (R6)
   assign irdy_n_o   = st_q != CBSC_DATA;
   assign ctl_oe_o   = frame_oe_o || tgt_q;
   assign ad_oe_o    = frame_oe_o;
   assign ad_o       = st_q == CBSC_ADDR ? req_lat_q.addr : req_lat_q.data;
   assign cbe_o      = st_q == CBSC_ADDR ? cmd_lat_q : req_lat_q.be; // (R17)
   assign lock_oe_o  = frame_oe_o && req_lat_q.lock;      // (R2)
   assign lock_n_o   = 1'b0;
   assign trdy_n_o   = !tgt_q;
   assign devsel_n_o = !tgt_q;

   // Parity one clock behind its data; target-side parity check
   always_ff @(posedge link_clk_i or negedge lrst_n_q) begin
      if (!lrst_n_q) begin
         par_en_q  <= 1'b0;
         par_q     <= 1'b0;
         tgt_q     <= 1'b0;
         perr_p1_q <= 1'b0;
         perr_p2_q <= 1'b0;
         texp_q    <= 1'b0;
         tcmd_q    <= CBSC_CMD_IDLE;
      end else begin
         par_en_q  <= ad_oe_o;
         par_q     <= par_calc_w;                         // (R16)
         // Claim any unlocked cycle framed by the card; no address is decoded
         tgt_q     <= claim_w;                            // (R4)
         // Keep the card's command so special cycles skip the check
         if (claim_w)
            tcmd_q <= cbe_i;
         // Data phase now; its parity bit only arrives a clock later
         perr_p1_q <= tgt_q && !irdy_n_i && tcmd_q != CBSC_CMD_SPEC;
         texp_q    <= rx_par_w;
         perr_p2_q <= perr_p1_q && (texp_q != par_i);     // (R10)
      end
   end
   assign par_oe_o  = par_en_q;
   assign par_o     = par_q;
   assign perr_oe_o = perr_p2_q;
   assign perr_n_o  = !perr_p2_q;

   // Arbiter: grant only with the bus idle and card requesting
   logic req_s1_q, req_s2_q, gnt_q;
   always_ff @(posedge link_clk_i or negedge lrst_n_q) begin
      if (!lrst_n_q) begin
         req_s1_q <= 1'b0;
         req_s2_q <= 1'b0;
         gnt_q    <= 1'b0;
      end else begin
         req_s1_q <= !req_n_i;                            // (R11)
         req_s2_q <= req_s1_q;
         // A pending host request wins the idle bus, else a card that
         // never drops its request would lock the host out for good
         gnt_q    <= req_s2_q && st_q == CBSC_IDLE && !new_req_w
                     && frame_n_i && irdy_n_i;            // (R7)
      end
   end
   assign gnt_n_o = !gnt_q;

   // ----------------------------------------------------------------
   // System side: request toggle, completion, status
   // ----------------------------------------------------------------
   logic       busy_q;
   logic [2:0] dn_s_q, ab_s_q;
   logic [1:0] int_s_q, serr_s_q, sts_s_q, aud_s_q;
   logic [3:0] sense_s1_q, sense_s2_q;
   logic       sts_d_q, serr_hold_q;

   assign req_ready_o = !busy_q;
   wire done_w  = dn_s_q[2] != dn_s_q[1];
   wire abort_w = ab_s_q[2] != ab_s_q[1];

   // Request captured then handed over by a toggle
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         busy_q  <= 1'b0;
         req_t_q <= 1'b0;
         done_o  <= 1'b0;
         abort_o <= 1'b0;
         dn_s_q  <= 3'h0;
         ab_s_q  <= 3'h0;
      end else if (clk_en_i) begin
         dn_s_q  <= {dn_s_q[1:0], done_t_q};
         ab_s_q  <= {ab_s_q[1:0], abort_t_q};
         done_o  <= done_w;
         abort_o <= abort_w;
         if (req_valid_i && !busy_q) begin
            busy_q  <= 1'b1;
            req_t_q <= ~req_t_q;
         end else if (done_w || abort_w) begin
            busy_q <= 1'b0;
         end
      end
   end

   // Request word captured on the system side when accepted and held while busy, then latched on the link side when idle
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         req_lat_hold_q <= '0;
      end else if (clk_en_i && req_valid_i && !busy_q) begin
         req_lat_hold_q <= req_i;
      end
   end
   always_ff @(posedge link_clk_i or negedge lrst_n_q) begin
      if (!lrst_n_q) begin
         req_lat_q <= '0;
      end else if (st_q == CBSC_IDLE && new_req_w) begin
         req_lat_q <= req_lat_hold_q;   // Stable while busy
      end
   end

   // Pin levels synchronised into the system clock
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         int_s_q    <= 2'h3;
         serr_s_q   <= 2'h3;
         sts_s_q    <= 2'h0;
         aud_s_q    <= 2'h0;
         sense_s1_q <= 4'hF;
         sense_s2_q <= 4'hF;
         sts_d_q    <= 1'b0;
         serr_hold_q <= 1'b0;
      end else if (clk_en_i) begin
         int_s_q    <= {int_s_q[0], int_n_i};
         serr_s_q   <= {serr_s_q[0], serr_n_i};
         sts_s_q    <= {sts_s_q[0], stschg_i};
         aud_s_q    <= {aud_s_q[0], audio_i};
         sense_s1_q <= sense_i;
         sense_s2_q <= sense_s1_q;
         sts_d_q    <= sts_s_q[1];
         // Slow pull-up release: level follows, no edge needed
         serr_hold_q <= !serr_s_q[1];                    // (R12)
      end
   end

   wire cbsc_sense_t sense_w = sense_s2_q;
   assign stat_o.present   = sense_w.detect_n == 2'b00;   // (R3)
   assign stat_o.card_type = sense_w.vsense;              // (R3)
   assign stat_o.irq       = !int_s_q[1];                 // (R8)
   assign stat_o.serr      = serr_hold_q;
   assign stat_o.wake      = sts_s_q[1];                  // (R15)
   assign stschg_o         = sts_s_q[1] && !sts_d_q;      // (R15)
   assign serr_n_o         = !serr_hold_q;                // (R13)
   assign speaker_out_o    = audio_en_i && aud_s_q[1];    // (R1)

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_perr_src;
      perr_p1_q && (texp_q != par_i);
   endsequence
   property p_perr_lag;
      @(posedge link_clk_i) disable iff (!lrst_n_q)
      s_perr_src |=> !perr_n_o;
   endproperty
   a_perr_lag: assert property (p_perr_lag)  // (R10)
      else $error("parity error not reported on time");

   property p_par_delay;
      @(posedge link_clk_i) disable iff (!lrst_n_q)
      ad_oe_o |=> par_oe_o && par_o == $past(par_calc_w);
   endproperty
   a_par_delay: assert property (p_par_delay)  // (R16)
      else $error("parity not one clock after data");

   property p_abort_timeout;
      @(posedge link_clk_i) disable iff (!lrst_n_q)
      (st_q == CBSC_DATA && !devsel_w && timeout_w && !xfer_w)
         |=> st_q == CBSC_TURN;
   endproperty
   a_abort_timeout: assert property (p_abort_timeout)  // (R5)
      else $error("initiator abort missed");

   property p_frame_final;
      @(posedge link_clk_i) disable iff (!lrst_n_q)
      st_q == CBSC_DATA |-> frame_n_o && frame_oe_o;
   endproperty
   a_frame_final: assert property (p_frame_final)  // (R6)
      else $error("frame asserted in final phase");

   property p_gnt_idle;
      @(posedge link_clk_i) disable iff (!lrst_n_q)
      !gnt_n_o |-> $past(st_q == CBSC_IDLE);
   endproperty
   a_gnt_idle: assert property (p_gnt_idle)  // (R7)
      else $error("grant during own transaction");

   property p_speaker;
      @(posedge clock_i) disable iff (!resetn_i)
      !audio_en_i |-> !speaker_out_o;
   endproperty
   a_speaker: assert property (p_speaker)  // (R1)
      else $error("speaker driven while audio off");

   property p_serr_fwd;
      @(posedge clock_i) disable iff (!resetn_i)
      (clk_en_i && !serr_s_q[1]) |=> !serr_n_o;
   endproperty
   a_serr_fwd: assert property (p_serr_fwd)  // (R13)
      else $error("system error not forwarded");

   property p_claim;
      @(posedge link_clk_i) disable iff (!lrst_n_q)
      claim_w |=> !devsel_n_o && !trdy_n_o && ctl_oe_o;
   endproperty
   a_claim: assert property (p_claim)  // (R4)
      else $error("target cycle not claimed");

endmodule

// >>> design/cbsc_pkg.sv
// Package for the CardBus socket control block: constants and carriers
package cbsc_pkg;

   // ----------------------------------------------------------------
   // Timing and widths
   // ----------------------------------------------------------------
   localparam int unsigned CBSC_ABORT_CLKS = 5;  // DEVSEL wait, link clocks
   localparam int unsigned CBSC_PERR_LAG   = 2;  // Parity error report lag
   localparam int unsigned CBSC_CMD_W      = 4;
   localparam int unsigned CBSC_DATA_W     = 32;
   localparam logic [3:0]  CBSC_CMD_IDLE   = 4'h0;
   localparam logic [3:0]  CBSC_CMD_SPEC   = 4'h1;  // Special cycle command

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   // Initiator request from the host side
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0]  cmd;
      logic [3:0]  be;
      logic        lock;
   } cbsc_req_t;

   // Socket sense lines after synchronisation
   typedef struct packed {
      logic [1:0] detect_n;
      logic [1:0] vsense;
   } cbsc_sense_t;

   // Socket status seen by the host
   typedef struct packed {
      logic       present;
      logic [1:0] card_type;
      logic       irq;
      logic       serr;
      logic       wake;
   } cbsc_stat_t;

endpackage

// >>> sim/cbsc_card.sv
// Card model: CardBus target and initiator as seen from the socket
module cbsc_card
   import cbsc_pkg::*;
(
   // Link clock and scenario controls
   input  wire logic        clk_i,
   input  wire logic        go_i,
   input  wire logic        bad_i,
   input  wire logic [1:0]  mode_i,
   // Resolved socket lines
   input  wire logic        frame_n_i,
   input  wire logic        irdy_n_i,
   input  wire logic        trdy_n_i,
   input  wire logic        devsel_n_i,
   input  wire logic        perr_n_i,
   input  wire logic [31:0] ad_i,
   input  wire logic [3:0]  cbe_i,
   input  wire logic        par_i,
   // Card drivers, enables high while driving
   output logic             ioe_o      = 1'b0,
   output logic             frame_n_o  = 1'b1,
   output logic             irdy_n_o   = 1'b1,
   output logic             toe_o      = 1'b0,
   output logic             devsel_n_o = 1'b1,
   output logic             trdy_n_o   = 1'b1,
   output logic             stop_n_o   = 1'b1,
   output logic [31:0]      ad_o       = 32'h0,
   output logic [3:0]       cbe_o      = 4'h0,
   output logic             poe_o      = 1'b0,
   output logic             par_o      = 1'b0,
   // Observations for the bench
   output logic [71:0]      cap_o      = 72'h0,
   output logic [3:0]       flg_o      = 4'h0,
   output logic [3:0]       cnt_o      = 4'h0
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [35:0] adr_q;

   // Target side; mode 0 prompt, 1 silent, 2 stop, 3 wait states
   task automatic respond();
      int w;
      adr_q = {ad_i, cbe_i};
      if (mode_i == 2'h1) begin
         // Silent card: the socket must give up by itself
         do @(posedge clk_i); while (!frame_n_i || !irdy_n_i);
         return;
      end
      toe_o <= 1'b1;
      devsel_n_o <= 1'b0;
      @(posedge clk_i);
      flg_o[0] <= (par_i === ^adr_q);
      for (w = 0; w < 3 && mode_i == 2'h3; w++) @(posedge clk_i);
      trdy_n_o <= (mode_i == 2'h2);
      stop_n_o <= (mode_i != 2'h2);
      for (w = 0; w < 20; w++) begin
         @(posedge clk_i);
         if (!irdy_n_i) break;
      end
      flg_o[1] <= frame_n_i;
      cap_o <= {adr_q, ad_i, cbe_i};
      devsel_n_o <= 1'b1;
      trdy_n_o <= 1'b1;
      stop_n_o <= 1'b1;
      @(posedge clk_i);
      toe_o <= 1'b0;
   endtask

   // Initiator side; mode 1 sends a special cycle, bad_i spoils parity
   task automatic initiate();
      int w;
      logic [3:0] cmd;
      cmd = (mode_i == 2'h1) ? CBSC_CMD_SPEC : 4'h7;
      ioe_o <= 1'b1;
      frame_n_o <= 1'b0;
      ad_o <= 32'h0000_2000;
      cbe_o <= cmd;
      @(posedge clk_i);
      frame_n_o <= 1'b1;
      irdy_n_o <= 1'b0;
      ad_o <= 32'h1234_ABCD;
      cbe_o <= 4'hF;
      poe_o <= 1'b1;
      par_o <= ^{32'h0000_2000, cmd};
      // Bounded, so a socket that never claims cannot hang us
      for (w = 0; w < 8; w++) begin
         @(posedge clk_i);
         if (!trdy_n_i) break;
      end
      flg_o[2] <= !devsel_n_i;
      irdy_n_o <= 1'b1;
      par_o <= ^{32'h1234_ABCD, 4'hF} ^ bad_i;
      @(posedge clk_i);
      ioe_o <= 1'b0;
      poe_o <= 1'b0;
      @(posedge clk_i);
      flg_o[3] <= (perr_n_i === !(bad_i && cmd != CBSC_CMD_SPEC));
      cnt_o <= cnt_o + 4'h1;
      while (go_i) @(posedge clk_i);
   endtask

   // Dispatch: start a cycle on request, else answer the socket
   initial begin
      forever begin
         @(posedge clk_i);
         if (go_i)
            initiate();
         else if (!frame_n_i)
            respond();
      end
   end
endmodule

// >>> sim/cbsc_core_tb.sv
// Testbench for the CardBus socket control block with a card model
`define CHK(a, e) \
   begin \
      check_count++; \
      if ((a) !== (e)) begin \
         errors++; \
         $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (e)); \
      end \
   end
`define WAITC(c) for (w = 0; w < 300 && !(c); w++) @(negedge clock_i);

module cbsc_core_tb;
   import cbsc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int unsigned LC = 4;  // Shortened device-select wait
   localparam logic [31:0] ADR = 32'h0000_4A10;
   localparam logic [31:0] DAT = 32'h3C5A_F00D;

   int          errors = 0;
   int          check_count = 0;
   int          w;
   logic        clock_i = 1'b0, link_clk_i = 1'b0, resetn_i = 1'b0;
   logic        req_valid_i = 1'b0, audio_en_i = 1'b0, audio_i = 1'b0;
   logic        req_n_i = 1'b1, int_n_i = 1'b1, serr_n_i = 1'b1;
   logic        stschg_i = 1'b0, go = 1'b0, bad = 1'b0, flt = 1'b0;
   logic [1:0]  mode = 2'h0;
   cbsc_req_t   req_i = '0;
   cbsc_sense_t sense_i = 4'hF;
   logic        req_ready_o, done_o, abort_o, serr_n_o, stschg_o, spk_o;
   logic        frame_n_o, frame_oe_o, irdy_n_o, trdy_n_o, devsel_n_o;
   logic        ctl_oe_o, lock_n_o, lock_oe_o, perr_n_o, perr_oe_o;
   logic        par_o, par_oe_o, ad_oe_o, gnt_n_o;
   logic [31:0] ad_o, m_ad, rdata;
   logic [3:0]  cbe_o, m_cbe, flg, cnt;
   cbsc_stat_t  stat_o;
   logic        m_ioe, m_frame, m_irdy, m_toe, m_dev, m_trdy, m_stop;
   logic        m_poe, m_par;
   logic [71:0] cap;

   // Pulled-up control lines; released data lines show a moving pattern
   wire frame_w = (!frame_oe_o | frame_n_o) & (!m_ioe | m_frame);
   wire irdy_w  = (!ctl_oe_o | irdy_n_o) & (!m_ioe | m_irdy);
   wire trdy_w  = (!ctl_oe_o | trdy_n_o) & (!m_toe | m_trdy);
   wire dev_w   = (!ctl_oe_o | devsel_n_o) & (!m_toe | m_dev);
   wire stop_w  = !m_toe | m_stop;
   wire lock_w  = !lock_oe_o | lock_n_o;
   wire perr_w  = !perr_oe_o | perr_n_o;
   wire [31:0] ad_w = ad_oe_o ? ad_o : m_ioe ? m_ad : {32{flt}} ^ ADR;
   wire [3:0]  cbe_w = ad_oe_o ? cbe_o : m_ioe ? m_cbe : {4{flt}};
   wire        par_w = par_oe_o ? par_o : m_poe ? m_par : flt;

   // System clock, and a link clock with an unrelated phase
   always #12.5 clock_i = ~clock_i;
   initial begin
      #37;
      forever #80 link_clk_i = ~link_clk_i;
   end
   always @(posedge link_clk_i) flt <= ~flt;

   cbsc_core #(.ABORT_CLKS(LC)) dut_u (
      .clock_i(clock_i), .resetn_i(resetn_i), .clk_en_i(1'b1),
      .link_clk_i(link_clk_i), .req_valid_i(req_valid_i),
      .req_ready_o(req_ready_o), .req_i(req_i), .done_o(done_o),
      .abort_o(abort_o), .rdata_o(rdata), .audio_en_i(audio_en_i),
      .stat_o(stat_o), .serr_n_o(serr_n_o), .stschg_o(stschg_o),
      .speaker_out_o(spk_o), .frame_n_i(frame_w), .frame_n_o(frame_n_o),
      .frame_oe_o(frame_oe_o), .irdy_n_i(irdy_w), .irdy_n_o(irdy_n_o),
      .trdy_n_i(trdy_w), .trdy_n_o(trdy_n_o), .devsel_n_i(dev_w),
      .devsel_n_o(devsel_n_o), .stop_n_i(stop_w), .ctl_oe_o(ctl_oe_o),
      .lock_n_i(lock_w), .lock_n_o(lock_n_o), .lock_oe_o(lock_oe_o),
      .perr_n_i(perr_w), .perr_n_o(perr_n_o), .perr_oe_o(perr_oe_o),
      .ad_i(ad_w), .ad_o(ad_o), .ad_oe_o(ad_oe_o), .cbe_i(cbe_w),
      .cbe_o(cbe_o), .par_i(par_w), .par_o(par_o), .par_oe_o(par_oe_o),
      .req_n_i(req_n_i), .gnt_n_o(gnt_n_o), .int_n_i(int_n_i),
      .serr_n_i(serr_n_i), .stschg_i(stschg_i), .audio_i(audio_i),
      .sense_i(sense_i));

   cbsc_card card_u (
      .clk_i(link_clk_i), .go_i(go), .bad_i(bad), .mode_i(mode),
      .frame_n_i(frame_w), .irdy_n_i(irdy_w), .trdy_n_i(trdy_w),
      .devsel_n_i(dev_w), .perr_n_i(perr_w), .ad_i(ad_w), .cbe_i(cbe_w),
      .par_i(par_w), .ioe_o(m_ioe), .frame_n_o(m_frame), .irdy_n_o(m_irdy),
      .toe_o(m_toe), .devsel_n_o(m_dev), .trdy_n_o(m_trdy),
      .stop_n_o(m_stop), .ad_o(m_ad), .cbe_o(m_cbe), .poe_o(m_poe),
      .par_o(m_par), .cap_o(cap), .flg_o(flg), .cnt_o(cnt));

   task automatic close_out();
      $display("errors=%0d checks=%0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // One host request; lock and early grant are watched meanwhile
   task automatic host(input logic [1:0] md, input logic lk, gr);
      logic lk_seen;
      logic gnt_early;
      lk_seen = 1'b0;
      gnt_early = 1'b0;
      mode = md;
      req_i = '{addr: ADR, data: DAT, cmd: 4'h7, be: 4'h6, lock: lk};
      req_valid_i = 1'b1;
      `WAITC(req_ready_o === 1'b1)
      @(negedge clock_i);
      req_valid_i = 1'b0;
      req_n_i = !gr;
      for (w = 0; w < 400 && done_o !== 1'b1 && abort_o !== 1'b1; w++) begin
         @(negedge clock_i);
         lk_seen |= lock_oe_o === 1'b1 && lock_n_o === 1'b0;
         gnt_early |= ctl_oe_o === 1'b1 && gnt_n_o === 1'b0;
      end
      `CHK({done_o, abort_o}, {md != 2'h1, md == 2'h1})
      `CHK(lk_seen, lk)
      `CHK(gnt_early, 1'b0)
   endtask

   task automatic t_write();
      for (int m = 0; m < 4; m += 3) begin
         host(2'(m), m == 3, 1'b0);
         `CHK(cap, {ADR, 4'h7, DAT, 4'h6})
         `CHK(flg[1:0], 2'h3)
         `CHK(rdata, DAT)
      end
   endtask

   task automatic t_grant();
      host(2'h2, 1'b0, 1'b1);
      `WAITC(gnt_n_o === 1'b0)
      `CHK(gnt_n_o, 1'b0)
      req_n_i = 1'b1;
      host(2'h1, 1'b0, 1'b0);
   endtask

   // Card-started cycles: clean, bad parity, special cycle with bad parity
   task automatic t_target();
      logic [3:0] c0;
      for (int k = 0; k < 3; k++) begin
         c0 = cnt;
         bad = k != 0;
         mode = (k == 2) ? 2'h1 : 2'h0;
         go = 1'b1;
         `WAITC(cnt !== c0)
         go = 1'b0;
         // Let the card see go low before the next cycle starts
         repeat (16) @(negedge clock_i);
         `CHK(cnt, c0 + 4'h1)
         `CHK(flg[3], 1'b1)
         `CHK(flg[2] | (k == 2), 1'b1)
      end
   endtask

   task automatic t_side();
      audio_en_i = 1'b1;
      audio_i = 1'b1;
      `WAITC(spk_o === 1'b1)
      `CHK(spk_o, 1'b1)
      audio_en_i = 1'b0;
      `WAITC(spk_o === 1'b0)
      `CHK(spk_o, 1'b0)
      for (int v = 0; v < 4; v++) begin
         sense_i = {2'b00, 2'(v)};
         `WAITC(stat_o.card_type === 2'(v) && stat_o.present === 1'b1)
         `CHK({stat_o.present, stat_o.card_type}, {1'b1, 2'(v)})
      end
      sense_i = 4'h4;
      `WAITC(stat_o.present === 1'b0)
      `CHK(stat_o.present, 1'b0)
      int_n_i = 1'b0;
      `WAITC(stat_o.irq === 1'b1)
      `CHK(stat_o.irq, 1'b1)
      serr_n_i = 1'b0;
      `WAITC(serr_n_o === 1'b0)
      `CHK({serr_n_o, stat_o.serr}, 2'b01)
      // Hold system error low for 26 system clocks, then release it in one step
      repeat (26) @(negedge clock_i);
      serr_n_i = 1'b1;
      `WAITC(serr_n_o === 1'b1)
      `CHK(serr_n_o, 1'b1)
      stschg_i = 1'b1;
      `WAITC(stschg_o === 1'b1)
      `CHK(stschg_o, 1'b1)
      @(negedge clock_i);
      `CHK(stschg_o, 1'b0)
      `CHK(stat_o.wake, 1'b1)
   endtask

   // Reset held six cycles, then the scenarios in turn
   initial begin
      repeat (6) @(negedge clock_i);
      resetn_i = 1'b1;
      repeat (3) @(posedge link_clk_i);
      @(negedge clock_i);
      `CHK({frame_oe_o, ctl_oe_o, ad_oe_o, perr_oe_o, gnt_n_o}, 5'h01)
      t_write();
      t_grant();
      t_target();
      t_side();
      close_out();
   end

   // Watchdog well beyond the expected run length
   initial begin
      #2_000_000;
      errors++;
      close_out();
   end
endmodule
